// file: pkg/expcap_pkg.sv
// constants, field layouts and carriers for the express capability register bank
//
// Overview of operation
// [R1] registers not applicable here read zero and ignore writes
// [R2] header reads id 0x01, next pointer 0x80, version 3, rest zero
// [R3] device capabilities bits 2:0 give build-time max payload, 128 or 256
// [R4] extended tag bit 5 and L0s/L1 latency fields are build-time read-only
// [R5] device capabilities bit 15 always reads one
// [R6] captured slot power bits 27:18 always read zero
// [R7] device capabilities bit 28 reports build-time function-level reset support
// [R8] control bits 0-3 are error reporting enables, read-write, reset zero
// [R9] relaxed ordering bit 4 build-time reset, ext tag bit 8 zero, no-snoop bit 11 one
// [R10] payload size bits 7:5 reset 0, read request size bits 14:12 reset 2
// [R11] writing one to bit 15 resets function if capable; reads zero
// [R12] status bit 21 reads one while a non-posted request is pending
// [R13] link capabilities bit 10 reports build-time L0s power management support
// [R14] link capabilities bit 11 reports build-time L1 power management support
// [R15] status bits 16-19 set on detected errors, cleared by writing one
// [R16] link speed bits 3:0, width bits 9:4 build-time; bit 22 reads one
package expcap_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] off_express_capability_header      = 12'h080;
    localparam logic [11:0] off_device_capabilities             = 12'h084;
    localparam logic [11:0] off_device_control_and_status       = 12'h088;
    localparam logic [11:0] off_link_capabilities               = 12'h08c;
    localparam logic [11:0] off_link_control_and_status         = 12'h090;
    localparam logic [11:0] off_slot_capabilities               = 12'h094;
    localparam logic [11:0] off_slot_control_and_status         = 12'h098;
    localparam logic [11:0] off_root_control_and_capabilities   = 12'h09c;
    localparam logic [11:0] off_root_status                     = 12'h0a0;
    localparam logic [11:0] off_device_capabilities_second      = 12'h0a4;
    localparam logic [11:0] off_device_control_status_second    = 12'h0a8;
    localparam logic [11:0] off_link_capabilities_second        = 12'h0ac;
    localparam logic [11:0] off_link_control_status_second      = 12'h0b0;
    localparam logic [11:0] off_irq_status                      = 12'h0c0;
    localparam logic [11:0] off_irq_mask                        = 12'h0c4;

    // ------------------------------------------------------------
    // header fields
    // ------------------------------------------------------------
    localparam logic [7:0]  cap_id_value       = 8'h01;
    localparam logic [7:0]  next_ptr_value     = 8'h80;
    localparam logic [2:0]  cap_version_value  = 3'h3;

    // ------------------------------------------------------------
    // device capabilities bit positions
    // ------------------------------------------------------------
    localparam int dcap_payload_lsb   = 0;
    localparam int dcap_ext_tag_bit   = 5;
    localparam int dcap_l0s_lat_lsb   = 6;
    localparam int dcap_l1_lat_lsb    = 9;
    localparam int dcap_role_err_bit  = 15;
    localparam int dcap_flr_bit       = 28;

    // ------------------------------------------------------------
    // device control / status bit positions and reset values
    // ------------------------------------------------------------
    localparam int dctl_err_en_lsb    = 0;
    localparam int dctl_relax_bit     = 4;
    localparam int dctl_payload_lsb   = 5;
    localparam int dctl_ext_tag_bit   = 8;
    localparam int dctl_no_snoop_bit  = 11;
    localparam int dctl_rd_req_lsb    = 12;
    localparam int dctl_flr_bit       = 15;
    localparam int dsts_err_lsb       = 16;
    localparam int dsts_pending_bit   = 21;
    localparam logic [3:0] err_en_reset   = 4'h0;
    localparam logic [2:0] payload_reset  = 3'h0;
    localparam logic       ext_tag_reset  = 1'b0;
    localparam logic       no_snoop_reset = 1'b1;
    localparam logic [2:0] rd_req_reset   = 3'h2;

    // ------------------------------------------------------------
    // link capabilities bit positions
    // ------------------------------------------------------------
    localparam int lcap_speed_lsb   = 0;
    localparam int lcap_width_lsb   = 4;
    localparam int lcap_l0s_bit     = 10;
    localparam int lcap_l1_bit      = 11;
    localparam int lcap_l0s_exit_lsb = 12;
    localparam int lcap_l1_exit_lsb  = 15;
    localparam int lcap_optional_bit = 22;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd_req_relax;
        logic [2:0] rd_req_size;
        logic       no_snoop;
        logic       ext_tag;
        logic [2:0] payload;
        logic       relax;
        logic [3:0] err_en;
    } dev_control_t;

    typedef struct packed {
        logic [3:0] err_seen;
        logic       pending;
    } dev_status_t;

endpackage

// file: src/expcap_regs.sv
// express capability register bank behind an ahb-lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module expcap_regs
    import expcap_pkg::*;
#(
    parameter logic [2:0] max_payload_cap   = 3'h0,
    parameter logic       ext_tag_cap       = 1'b0,
    parameter logic [2:0] l0s_accept_lat    = 3'h0,
    parameter logic [2:0] l1_accept_lat     = 3'h0,
    parameter logic       flr_cap           = 1'b1,
    parameter logic       relax_reset       = 1'b0,
    parameter logic [3:0] max_link_speed    = 4'h1,
    parameter logic [5:0] max_link_width    = 6'h01,
    parameter logic       aspm_l0s_cap      = 1'b0,
    parameter logic       aspm_l1_cap       = 1'b0,
    parameter logic [2:0] l0s_exit_lat      = 3'h6,
    parameter logic [2:0] l1_exit_lat       = 3'h0
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output var  logic                     hreadyout,
    output var  logic                     hresp,
    output var  logic [31:0]              hrdata,
    input  wire logic [3:0]               err_detect,
    input  wire logic                     np_pending,
    output var  expcap_pkg::dev_control_t dev_control,
    output var  logic                     flr_pulse,
    output var  logic                     irq
);
    import expcap_pkg::*;

    // ------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------
    logic        wr_pend;
    logic [11:0] addr_q;
    wire         take     = hsel & hready & htrans[1];
    wire         take_wr  = take & hwrite;
    wire         take_rd  = take & ~hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            addr_q  <= 12'h000;
        end else begin
            wr_pend <= take_wr;
            if (take) begin
                addr_q <= {haddr[11:2], 2'b00};
            end
        end
    end

    // a read right behind a write waits one cycle so it sees the new value; always okay
    wire   rd_behind_wr = hsel & htrans[1] & ~hwrite & wr_pend;
    assign hreadyout    = ~rd_behind_wr;
    assign hresp        = 1'b0;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // reads decode in the address phase, writes in the data phase
    wire [11:0] rd_addr = {haddr[11:2], 2'b00};
    wire sel_hdr  = (rd_addr == off_express_capability_header);
    wire sel_dcap = (rd_addr == off_device_capabilities);
    wire sel_dctl = (rd_addr == off_device_control_and_status);
    wire sel_lcap = (rd_addr == off_link_capabilities);
    wire sel_ist  = (rd_addr == off_irq_status);
    wire sel_imsk = (rd_addr == off_irq_mask);
    wire wr_dctl  = wr_pend & (addr_q == off_device_control_and_status);
    wire wr_ist   = wr_pend & (addr_q == off_irq_status);
    wire wr_imsk  = wr_pend & (addr_q == off_irq_mask);

    // ------------------------------------------------------------
    // device control
    // ------------------------------------------------------------
    dev_control_t ctl;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // [R8] error enables reset zero
            ctl.err_en      <= err_en_reset;
            // [R9] build-time relax reset
            ctl.relax       <= relax_reset;
            ctl.ext_tag     <= ext_tag_reset;
            ctl.no_snoop    <= no_snoop_reset;
            // [R10] size field resets
            ctl.payload     <= payload_reset;
            ctl.rd_req_size <= rd_req_reset;
            ctl.rd_req_relax <= 1'b0;
        end else if (flr_pulse) begin
            // [R11] function reset restores defaults
            ctl.err_en      <= err_en_reset;
            ctl.relax       <= relax_reset;
            ctl.ext_tag     <= ext_tag_reset;
            ctl.no_snoop    <= no_snoop_reset;
            ctl.payload     <= payload_reset;
            ctl.rd_req_size <= rd_req_reset;
            ctl.rd_req_relax <= 1'b0;
        end else if (wr_dctl) begin
            // [R8] error enable write
            ctl.err_en      <= hwdata[dctl_err_en_lsb +: 4];
            // [R9] ordering and tag writes
            ctl.relax       <= hwdata[dctl_relax_bit];
            ctl.ext_tag     <= hwdata[dctl_ext_tag_bit];
            ctl.no_snoop    <= hwdata[dctl_no_snoop_bit];
            // [R10] size field writes
            ctl.payload     <= hwdata[dctl_payload_lsb +: 3];
            ctl.rd_req_size <= hwdata[dctl_rd_req_lsb +: 3];
            ctl.rd_req_relax <= 1'b0;
        end
    end

    assign dev_control = ctl;

    // ------------------------------------------------------------
    // function level reset trigger
    // ------------------------------------------------------------
    // [R11] fires only when capable
    wire next_flr = wr_dctl & hwdata[dctl_flr_bit] & flr_cap;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flr_pulse <= 1'b0;
        end else begin
            flr_pulse <= next_flr;
        end
    end

    // ------------------------------------------------------------
    // error detected flags and interrupt status
    // ------------------------------------------------------------
    logic [3:0] err_seen;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    // [R15] write one clears
    wire  [3:0] err_clr = wr_dctl ? hwdata[dsts_err_lsb +: 4] : 4'h0;
    wire  [3:0] ist_clr = wr_ist ? hwdata[3:0] : 4'h0;

    sticky_flags #(
        .width (4)
    ) u_err_flags (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (err_detect),
        .clear   (err_clr),
        .flags   (err_seen)
    );

    sticky_flags #(
        .width (4)
    ) u_irq_flags (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (err_detect),
        .clear   (ist_clr),
        .flags   (irq_stat)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= 4'h0;
        end else if (wr_imsk) begin
            irq_mask <= hwdata[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // read values
    // ------------------------------------------------------------
    logic [31:0] hdr_word;
    logic [31:0] dcap_word;
    logic [31:0] dctl_word;
    logic [31:0] lcap_word;

    always_comb begin
        // [R2] fixed header word
        hdr_word = {13'h0000, cap_version_value, next_ptr_value, cap_id_value};
    end

    always_comb begin
        // [R6] slot power bits stay zero
        dcap_word = 32'h0000_0000;
        // [R3] build-time payload
        dcap_word[dcap_payload_lsb +: 3] = max_payload_cap;
        // [R4] tag and latency fields
        dcap_word[dcap_ext_tag_bit]      = ext_tag_cap;
        dcap_word[dcap_l0s_lat_lsb +: 3] = l0s_accept_lat;
        dcap_word[dcap_l1_lat_lsb +: 3]  = l1_accept_lat;
        // [R5] role based error always one
        dcap_word[dcap_role_err_bit]     = 1'b1;
        // [R7] flr capability
        dcap_word[dcap_flr_bit]          = flr_cap;
    end

    always_comb begin
        dctl_word = 32'h0000_0000;
        dctl_word[dctl_err_en_lsb +: 4]  = ctl.err_en;
        dctl_word[dctl_relax_bit]        = ctl.relax;
        dctl_word[dctl_payload_lsb +: 3] = ctl.payload;
        dctl_word[dctl_ext_tag_bit]      = ctl.ext_tag;
        dctl_word[dctl_no_snoop_bit]     = ctl.no_snoop;
        dctl_word[dctl_rd_req_lsb +: 3]  = ctl.rd_req_size;
        // [R11] trigger reads zero
        dctl_word[dctl_flr_bit]          = 1'b0;
        dctl_word[dsts_err_lsb +: 4]     = err_seen;
        // [R12] pending request flag
        dctl_word[dsts_pending_bit]      = np_pending;
    end

    always_comb begin
        lcap_word = 32'h0000_0000;
        // [R16] speed, width, optionality
        lcap_word[lcap_speed_lsb +: 4]    = max_link_speed;
        lcap_word[lcap_width_lsb +: 6]    = max_link_width;
        lcap_word[lcap_optional_bit]      = 1'b1;
        // [R13] l0s power management support
        lcap_word[lcap_l0s_bit]           = aspm_l0s_cap;
        // [R14] l1 power management support
        lcap_word[lcap_l1_bit]            = aspm_l1_cap;
        lcap_word[lcap_l0s_exit_lsb +: 3] = l0s_exit_lat;
        lcap_word[lcap_l1_exit_lsb +: 3]  = l1_exit_lat;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // [R1] other offsets read zero
    wire [31:0] rd_word = sel_hdr  ? hdr_word  :
                          sel_dcap ? dcap_word :
                          sel_dctl ? dctl_word :
                          sel_lcap ? lcap_word :
                          sel_ist  ? {28'h0000000, irq_stat} :
                          sel_imsk ? {28'h0000000, irq_mask} :
                          32'h0000_0000;

    // loaded at the address edge, stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take_rd) begin
            hrdata <= rd_word;
        end
    end
endmodule
`default_nettype wire

// file: src/sticky_flags.sv
// write-one-to-clear sticky flag bank
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int width = 4
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [width-1:0] set,
    input  wire logic [width-1:0] clear,
    output var  logic [width-1:0] flags
);
    // ------------------------------------------------------------
    // flag bits
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < width; i++) begin : g_flag
            // [R15] set wins over clear
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= set[i] | (flags[i] & ~clear[i]);
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: test/cfg_host_model.sv
// host-side configuration requester on the ahb-lite register bus
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    task automatic wait_ready(inout int n);
        do begin
            @(posedge hclk);
            n++;
        end while ((hready !== 1'b1 || hresetn !== 1'b1) && n < 64);
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready(n);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready(n);
        q = hrdata;
        hwdata <= ~d;
        if (n >= 64) tb.hang();
    endtask
endmodule
`default_nettype wire

// file: test/expcap_asserts.sv
// assertion checker for the express capability register bank
`timescale 1ns/1ps
`default_nettype none
module expcap_asserts
    import expcap_pkg::*;
#(
    parameter logic flr_cap      = 1'b1,
    parameter logic relax_reset  = 1'b0,
    parameter logic aspm_l0s_cap = 1'b0,
    parameter logic aspm_l1_cap  = 1'b0
) (
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     hsel,
    input wire logic [31:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    input wire logic [31:0]              hrdata,
    input wire logic                     flr_pulse,
    input wire logic                     irq,
    input wire expcap_pkg::dev_control_t dev_control
);
    // ------------------------------------------------------------
    // decode of accepted requests
    // ------------------------------------------------------------
    wire logic        take     = hsel && hready && htrans[1];
    wire logic        wr_ctl   = take && hwrite && haddr[11:2] == 10'h022;
    wire logic        rd_hdr   = take && !hwrite && haddr[11:2] == 10'h020;
    wire logic        rd_dcap  = take && !hwrite && haddr[11:2] == 10'h021;
    wire logic        rd_ctl   = take && !hwrite && haddr[11:2] == 10'h022;
    wire logic        rd_lcap  = take && !hwrite && haddr[11:2] == 10'h023;
    wire logic        rd_rsv   = take && !hwrite && haddr[11:2] >= 10'h024 && haddr[11:2] <= 10'h02c;
    wire logic [14:0] ctl_dflt = {1'b0, 3'h2, 1'b1, 1'b0, 3'h0, relax_reset, 4'h0};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_hdr; rd_hdr |-> ##1 hrdata == 32'h00038001; endproperty
    a_hdr: assert property (p_hdr) else $error("header word wrong");
    property p_dcap; rd_dcap |-> ##1 hrdata[15] && hrdata[27:18] == 10'h0 && hrdata[28] == flr_cap; endproperty
    a_dcap: assert property (p_dcap) else $error("device caps fixed bits wrong");
    property p_lcap; rd_lcap |-> ##1 hrdata[22] && hrdata[11:10] == {aspm_l1_cap, aspm_l0s_cap}; endproperty
    a_lcap: assert property (p_lcap) else $error("link caps fixed bits wrong");
    property p_rsv; rd_rsv |-> ##1 hrdata == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved word not zero");
    property p_ctl_rd; rd_ctl |-> ##1 !hrdata[15] && !hrdata[20] && hrdata[31:22] == 10'h0; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control word zero bits wrong");
    property p_err_en; wr_ctl ##1 !hwdata[15] |=> dev_control.err_en == $past(hwdata[3:0]); endproperty
    a_err_en: assert property (p_err_en) else $error("error enables not written");
    property p_fields;
        wr_ctl ##1 !hwdata[15] |=> dev_control.payload == $past(hwdata[7:5])
            && dev_control.rd_req_size == $past(hwdata[14:12]) && dev_control.no_snoop == $past(hwdata[11]);
    endproperty
    a_fields: assert property (p_fields) else $error("control fields not written");
    property p_flr_req; wr_ctl ##1 hwdata[15] |=> flr_pulse == flr_cap; endproperty
    a_flr_req: assert property (p_flr_req) else $error("reset request not issued");
    property p_flr_cause; flr_pulse |-> $past(hwdata[15]) && $past(wr_ctl, 2); endproperty
    a_flr_cause: assert property (p_flr_cause) else $error("reset request without write");
    property p_flr_dflt; flr_pulse |=> dev_control == ctl_dflt && !flr_pulse; endproperty
    a_flr_dflt: assert property (p_flr_dflt) else $error("control not reset after request");

    c_flr: cover property (flr_pulse);
    c_irq: cover property (irq);
    c_err: cover property (rd_ctl ##1 hrdata[16]);
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking testbench for the express capability register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import expcap_pkg::*;
    localparam logic [2:0]  pay   = 3'h1;
    localparam logic [2:0]  l0s_l = 3'h5;
    localparam logic [2:0]  l1_l  = 3'h3;
    localparam logic [3:0]  spd   = 4'h3;
    localparam logic [5:0]  wid   = 6'h08;
    localparam logic [2:0]  l0s_x = 3'h4;
    localparam logic [2:0]  l1_x  = 3'h2;
    localparam logic [31:0] hdr   = 32'h00038001;
    localparam logic [31:0] dcap  = {3'h0, 1'b1, 10'h0, 2'h0, 1'b1, 3'h0, l1_l, l0s_l, 1'b1, 2'h0, pay};
    localparam logic [31:0] lcap  = {9'h0, 1'b1, 4'h0, l1_x, l0s_x, 1'b0, 1'b1, wid, spd};
    localparam logic [31:0] ctl0  = {16'h0, 1'b0, 3'h2, 1'b1, 2'h0, 1'b0, 3'h0, 1'b1, 4'h0};
    localparam logic [14:0] ctlp  = {1'b0, 3'h2, 1'b1, 1'b0, 3'h0, 1'b1, 4'h0};
    logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, flr_pulse, irq, np_pending;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [3:0]   err_detect;
    dev_control_t dev_control;
    int           n_errors, cmp_count, flr_seen;
    assign hready = hreadyout;

    expcap_regs #(.max_payload_cap(pay), .ext_tag_cap(1'b1), .l0s_accept_lat(l0s_l), .l1_accept_lat(l1_l),
        .flr_cap(1'b1), .relax_reset(1'b1), .max_link_speed(spd), .max_link_width(wid), .aspm_l0s_cap(1'b1),
        .aspm_l1_cap(1'b0), .l0s_exit_lat(l0s_x), .l1_exit_lat(l1_x)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .err_detect(err_detect), .np_pending(np_pending), .dev_control(dev_control),
        .flr_pulse(flr_pulse), .irq(irq));
    cfg_host_model host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        end_sim();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    always @(posedge hclk) if (flr_pulse === 1'b1) flr_seen <= flr_seen + 1;

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        err_detect = 4'h0;
        np_pending = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        flr_seen = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(12'h080, hdr);
        chk({31'h0, hresp}, 32'h0);
        wr(12'h080, 32'hffffffff);
        rd(12'h080, hdr);
        rd(12'h084, dcap);
        wr(12'h084, 32'hffffffff);
        rd(12'h084, dcap);
        rd(12'h08c, lcap);
        $display("test capabilities done");
        rd(12'h088, ctl0);
        wr(12'h088, 32'hffff7fff);
        rd(12'h088, 32'h000079ff);
        wr(12'h088, 32'h0000ffff);
        rd(12'h088, ctl0);
        chk(flr_seen, 32'h1);
        chk({17'h0, dev_control}, {17'h0, ctlp});
        $display("test control done");
        np_pending <= 1'b1;
        rd(12'h088, ctl0 | 32'h00200000);
        np_pending <= 1'b0;
        rd(12'h088, ctl0);
        $display("test pending done");
        wr(12'h0c4, 32'h00000007);
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            err_detect <= 4'h1 << i;
            @(posedge hclk);
            err_detect <= 4'h0;
            wr(12'h088, ctl0);
            rd(12'h088, ctl0 | (32'h1 << (16 + i)));
            chk({31'h0, irq}, {31'h0, i < 3});
            wr(12'h0c0, 32'h1 << i);
            wr(12'h088, ctl0 | (32'h1 << (16 + i)));
            rd(12'h088, ctl0);
            chk({31'h0, irq}, 32'h0);
        end
        $display("test errors done");
        for (int a = 12'h090; a <= 12'h0bc; a += 4) begin
            wr(a[11:0], 32'hffffffff);
            rd(a[11:0], 32'h0);
        end
        rd(12'h100, 32'h0);
        $display("test reserved done");
        end_sim();
    end
endmodule

bind expcap_regs expcap_asserts #(.flr_cap(flr_cap), .relax_reset(relax_reset), .aspm_l0s_cap(aspm_l0s_cap),
    .aspm_l1_cap(aspm_l1_cap)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .flr_pulse(flr_pulse), .irq(irq), .dev_control(dev_control));
`default_nettype wire
